// ==== src/supervisor_pkg.sv ====
// Package for the supply supervisor: timing constants, state encoding and carrier structs.
// Assumes a 200 MHz reference clock; all counts are derived from that rate.
package supervisor_pkg;

  // Reference clock rate.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // Manual reset glitch rejection time, in ns; a least time, so rounded up.
  localparam int unsigned MANUAL_GLITCH_NS = 100;
  localparam int unsigned MANUAL_GLITCH_CYC = (MANUAL_GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Shortest strobe pulse that must be seen, in ns; a longest sampling gap, so rounded down.
  localparam int unsigned STROBE_PULSE_NS = 50;
  localparam int unsigned STROBE_PULSE_CYC = (STROBE_PULSE_NS * 1000) / CLK_PERIOD_PS;

  // Reset hold period in ms (least time, round up) and watchdog timeout in ms (typical).
  localparam longint unsigned RESET_HOLD_MS = 140;
  localparam longint unsigned RESET_HOLD_CYC = (RESET_HOLD_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned WD_TIMEOUT_MS = 1600;
  localparam longint unsigned WD_TIMEOUT_CYC = (WD_TIMEOUT_MS * CLK_HZ) / 1000;

  // Counter widths.
  localparam int unsigned CNT_W = 32;
  localparam int unsigned FILT_W = 8;

  // Output state after reset.
  localparam logic RESET_OUT_INIT = 1'b0;

  // Reset output sequencer states.
  typedef enum logic [1:0] {
    ST_ASSERT = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN = 2'b10
  } out_state_t;

  // Strobe pin as seen by the core: level and whether it is actively driven.
  typedef struct packed {
    logic level;
    logic driven;
  } strobe_pin_t;

  // Status seen by the system around the block.
  typedef struct packed {
    logic cause_supply;
    logic cause_manual;
    logic cause_watchdog;
    logic watchdog_armed;
  } status_t;

endpackage : supervisor_pkg

// ==== src/glitch_filter.sv ====
// Synchroniser plus low-glitch filter for the active-low manual reset input.
// Assumes the input may be asynchronous; a low must persist more than REJECT_CYC cycles to pass.
`timescale 1ns/1ps
module glitch_filter #(
  parameter int unsigned REJECT_CYC = supervisor_pkg::MANUAL_GLITCH_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Raw and filtered level
  input wire logic i_raw_n,
  output logic o_filt_n
);
  import supervisor_pkg::*;

  logic meta_r;
  logic sync_r;
  logic [FILT_W-1:0] low_cnt_r;
  logic [FILT_W-1:0] low_cnt_nxt;
  logic filt_r;
  logic low_long;

  assign low_long = (low_cnt_r >= FILT_W'(REJECT_CYC));
  assign low_cnt_nxt = sync_r ? '0 : (low_long ? low_cnt_r : low_cnt_r + 8'h01);
  assign o_filt_n = filt_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      low_cnt_r <= '0;
      filt_r <= 1'b1;
    end
    else
    begin
      meta_r <= i_raw_n;
      sync_r <= meta_r;
      low_cnt_r <= low_cnt_nxt;
      // Lows shorter than the reject time never reach the output; highs pass at once.
      filt_r <= sync_r | ~low_long;
    end
  end

  glitch_reject_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $fell(o_filt_n) |-> $past(low_cnt_r) >= FILT_W'(REJECT_CYC))
    else $error("Manual reset passed before the reject time.");

endmodule : glitch_filter

// ==== src/supply_supervisor_watchdog_reset.sv ====
// Supervisory reset generator: undervoltage, manual reset and watchdog causes, fixed hold.
// Assumes i_supply_low comes from an analog comparator as a logic level, and that the pin
// front end reports whether the strobe pin is actively driven (window comparator).
//
// Notes on behaviour
// - Reset active for undervoltage, manual low, watchdog expiry.
// - Hold reset a fixed period after cause ends.
// - Reset output active-low, always driven.
// - Manual low asserts; rising edge starts hold.
// - Manual input ignores short low glitches.
// - Each strobe edge clears the watchdog counter.
// - Any reset assertion clears the watchdog counter.
// - Watchdog held cleared while reset is asserted.
// - Floating strobe disconnects watchdog from reset.
`timescale 1ns/1ps
module supply_supervisor_watchdog_reset #(
  parameter longint unsigned HOLD_CYC = supervisor_pkg::RESET_HOLD_CYC,
  parameter longint unsigned WD_CYC = supervisor_pkg::WD_TIMEOUT_CYC,
  parameter int unsigned MANUAL_REJECT_CYC = supervisor_pkg::MANUAL_GLITCH_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Reset causes
  input wire logic i_supply_low,
  input wire logic i_manual_reset_n,
  input wire supervisor_pkg::strobe_pin_t i_watchdog_strobe_in,
  // Reset to the host processor
  output logic o_host_reset_n,
  output logic o_host_reset_oe,
  // Status
  output supervisor_pkg::status_t o_status
);
  import supervisor_pkg::*;

  logic sup_meta_r;
  logic sup_sync_r;
  logic man_filt_n;
  logic [1:0] stb_meta_r;
  logic [1:0] stb_sync_r;
  logic stb_prev_r;
  logic stb_edge;
  logic stb_armed;
  logic [CNT_W-1:0] wd_cnt_r;
  logic [CNT_W-1:0] wd_cnt_nxt;
  logic wd_expire;
  logic [CNT_W-1:0] hold_cnt_r;
  logic [CNT_W-1:0] hold_cnt_nxt;
  logic hold_done;
  logic cause_any;
  logic wd_fire_r;
  out_state_t state_r;
  out_state_t state_nxt;
  logic reset_n_r;
  status_t status_r;

  // Undervoltage level synchroniser.
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      sup_meta_r <= 1'b1;
      sup_sync_r <= 1'b1;
    end
    else
    begin
      sup_meta_r <= i_supply_low;
      sup_sync_r <= sup_meta_r;
    end
  end

  // Manual reset synchroniser and low-glitch filter.
  glitch_filter #(
    .REJECT_CYC(MANUAL_REJECT_CYC)
  ) u_manual_filter (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_raw_n(i_manual_reset_n),
    .o_filt_n(man_filt_n)
  );

  // Strobe level and drive-detect synchronisers; sampled every 5 ns, so 50 ns pulses are seen.
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      stb_meta_r <= 2'h0;
      stb_sync_r <= 2'h0;
      stb_prev_r <= 1'b0;
    end
    else
    begin
      stb_meta_r <= {i_watchdog_strobe_in.driven, i_watchdog_strobe_in.level};
      stb_sync_r <= stb_meta_r;
      stb_prev_r <= stb_sync_r[0];
    end
  end

  assign stb_edge = stb_sync_r[0] ^ stb_prev_r;
  assign stb_armed = stb_sync_r[1];

  // Watchdog counter: cleared by strobe edges and whenever reset is active.
  assign wd_expire = (wd_cnt_r >= CNT_W'(WD_CYC - 1));
  assign wd_cnt_nxt = (!reset_n_r || stb_edge || wd_expire) ? '0 : wd_cnt_r + 32'h1;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      wd_cnt_r <= '0;
      wd_fire_r <= 1'b0;
    end
    else
    begin
      wd_cnt_r <= wd_cnt_nxt;
      // An expiry only reaches the reset logic while the strobe pin is driven.
      wd_fire_r <= wd_expire && stb_armed && reset_n_r && !stb_edge;
    end
  end

  // Output sequencer.
  assign cause_any = sup_sync_r || !man_filt_n || wd_fire_r;
  assign hold_done = (hold_cnt_r >= CNT_W'(HOLD_CYC - 1));

  always_comb
  begin
    state_nxt = state_r;
    hold_cnt_nxt = '0;
    case (state_r)
      ST_ASSERT:
      begin
        if (!cause_any)
        begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (cause_any)
        begin
          state_nxt = ST_ASSERT;
        end
        else if (hold_done)
        begin
          state_nxt = ST_RUN;
        end
        else
        begin
          hold_cnt_nxt = hold_cnt_r + 32'h1;
        end
      end
      ST_RUN:
      begin
        if (cause_any)
        begin
          state_nxt = ST_ASSERT;
        end
      end
      default:
      begin
        state_nxt = ST_ASSERT;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      state_r <= ST_ASSERT;
      hold_cnt_r <= '0;
      reset_n_r <= RESET_OUT_INIT;
      status_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      reset_n_r <= (state_nxt == ST_RUN);
      status_r <= '{cause_supply: sup_sync_r, cause_manual: !man_filt_n,
                    cause_watchdog: wd_fire_r, watchdog_armed: stb_armed};
    end
  end

  // Push-pull output: always driven.
  assign o_host_reset_n = reset_n_r;
  assign o_host_reset_oe = 1'b1;
  assign o_status = status_r;

  supply_asserts_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    sup_sync_r |=> !o_host_reset_n)
    else $error("Reset not asserted during undervoltage.");

  manual_asserts_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !man_filt_n |=> !o_host_reset_n)
    else $error("Reset not asserted during manual reset.");

  hold_min_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(o_host_reset_n) |-> $past(hold_cnt_r) == CNT_W'(HOLD_CYC - 1))
    else $error("Reset released before the full hold period.");

  wd_cleared_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !o_host_reset_n |=> wd_cnt_r == '0)
    else $error("Watchdog counted while reset was active.");

  strobe_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    stb_edge |=> wd_cnt_r == '0)
    else $error("Strobe edge did not clear the watchdog.");

  float_blocks_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !$past(stb_armed) |-> !wd_fire_r)
    else $error("Watchdog fired with strobe floating.");

  wd_fires_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (wd_expire && stb_armed && reset_n_r && !stb_edge) |=> ##1 !o_host_reset_n)
    else $error("Watchdog expiry did not assert reset.");

  always_driven_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_host_reset_oe && (o_host_reset_n == (state_r == ST_RUN)))
    else $error("Reset output not driven or of wrong polarity.");

  release_cover: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) $rose(o_host_reset_n));
  wd_cover: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) wd_fire_r);
  manual_cover: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) $fell(man_filt_n));
  hold_abort_cover: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state_r == ST_HOLD && cause_any);

endmodule : supply_supervisor_watchdog_reset

// ==== dv/host_model.sv ====
// Host processor model that services the watchdog strobe and can float the strobe pin.
// Assumes the bench drives i_service and i_float from the same reference clock.
`timescale 1ns/1ps
module host_model #(
  parameter int PERIOD = 60
) (
  // Clock and host reset
  input wire logic i_ref_clk,
  input wire logic i_host_reset_n,
  // Behaviour control
  input wire logic i_service,
  input wire logic i_float,
  // Strobe pin
  output supervisor_pkg::strobe_pin_t o_strobe
);
  import supervisor_pkg::*;
  int cnt_r = 0;
  logic level_r = 1'b0;
  logic run;
  assign run = i_service && i_host_reset_n;
  // Brief high pulse once per loop, low otherwise; stopping service leaves the pin stuck low.
  always @(posedge i_ref_clk)
  begin
    cnt_r <= (!run || cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
    level_r <= run && (cnt_r < 4);
  end
  // A floating pin shows the inverse of level_r, the level the model would drive.
  assign o_strobe = '{level: (i_float ? ~level_r : level_r), driven: !i_float};
endmodule : host_model

// ==== dv/supply_supervisor_watchdog_reset_test.sv ====
// Self-checking bench for the supply supervisor with shortened hold and timeout counts.
// Assumes host_model stands on the strobe pin and receives the host reset.
`timescale 1ns/1ps
module supply_supervisor_watchdog_reset_test;
  import supervisor_pkg::*;
  localparam int HOLD = 50;
  localparam int WD = 200;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_supply_low = 1'b0;
  logic i_manual_reset_n = 1'b1;
  logic service = 1'b0;
  logic float_pin = 1'b0;
  strobe_pin_t strobe;
  logic o_host_reset_n;
  logic o_host_reset_oe;
  status_t o_status;
  int n_errors = 0;
  int cmp_count = 0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  supply_supervisor_watchdog_reset #(.HOLD_CYC(HOLD), .WD_CYC(WD), .MANUAL_REJECT_CYC(MANUAL_GLITCH_CYC)) dut (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_supply_low(i_supply_low),
    .i_manual_reset_n(i_manual_reset_n),
    .i_watchdog_strobe_in(strobe),
    .o_host_reset_n(o_host_reset_n),
    .o_host_reset_oe(o_host_reset_oe),
    .o_status(o_status)
  );
  host_model #(.PERIOD(60)) host (
    .i_ref_clk(i_ref_clk),
    .i_host_reset_n(o_host_reset_n),
    .i_service(service),
    .i_float(float_pin),
    .o_strobe(strobe)
  );
  task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic conclude();
    $display("compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // Host reset must keep level v for n cycles.
  task automatic stay(input logic v, input int n, input string msg);
    int bad;
    bad = 0;
    repeat (n)
    begin
      @(negedge i_ref_clk);
      if (o_host_reset_n !== v)
        bad++;
    end
    check({3'h0, bad == 0}, 4'h1, msg);
  endtask : stay
  // Bounded wait for host reset to reach level v; running out ends the run.
  task automatic wait_rst(input logic v, input int bound, input string msg);
    int n;
    n = 0;
    while (o_host_reset_n !== v && n < bound)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    check({3'h0, o_host_reset_n === v}, 4'h1, msg);
    if (o_host_reset_n !== v)
      conclude();
  endtask : wait_rst
  task automatic t_power_up();
    stay(1'b0, HOLD, "early release after reset");
    wait_rst(1'b1, 12, "no release after reset");
    check({3'h0, o_host_reset_oe}, 4'h1, "output not driven");
    $display("done: power up");
  endtask : t_power_up
  task automatic t_supply();
    @(posedge i_ref_clk) i_supply_low <= 1'b1;
    wait_rst(1'b0, 6, "supply low not seen");
    repeat (20) @(posedge i_ref_clk);
    check({3'h0, o_status.cause_supply}, 4'h1, "supply cause");
    check({3'h0, o_status.cause_watchdog}, 4'h0, "watchdog cause in supply reset");
    check({3'h0, o_host_reset_oe}, 4'h1, "output not driven in reset");
    i_supply_low <= 1'b0;
    stay(1'b0, HOLD, "supply hold short");
    wait_rst(1'b1, 12, "supply hold long");
    $display("done: supply");
  endtask : t_supply
  task automatic t_manual();
    @(posedge i_ref_clk) i_manual_reset_n <= 1'b0;
    repeat (MANUAL_GLITCH_CYC) @(posedge i_ref_clk);
    i_manual_reset_n <= 1'b1;
    stay(1'b1, 40, "glitch caused reset");
    @(posedge i_ref_clk) i_manual_reset_n <= 1'b0;
    wait_rst(1'b0, 30, "manual low ignored");
    repeat (10) @(posedge i_ref_clk);
    check({3'h0, o_status.cause_manual}, 4'h1, "manual cause");
    i_manual_reset_n <= 1'b1;
    stay(1'b0, HOLD, "manual hold short");
    wait_rst(1'b1, 12, "manual hold long");
    $display("done: manual");
  endtask : t_manual
  task automatic t_service();
    stay(1'b1, 3 * WD, "serviced watchdog fired");
    check({3'h0, o_status.watchdog_armed}, 4'h1, "driven strobe not armed");
    $display("done: service");
  endtask : t_service
  task automatic t_restart();
    @(posedge i_ref_clk) i_nrst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    stay(1'b0, HOLD, "restart released early");
    wait_rst(1'b1, 12, "no release after restart");
    $display("done: restart");
  endtask : t_restart
  task automatic t_expiry();
    @(posedge i_ref_clk) service <= 1'b0;
    wait_rst(1'b0, WD + 20, "no watchdog reset");
    check({3'h0, o_status.cause_watchdog}, 4'h1, "watchdog cause");
    stay(1'b0, HOLD, "watchdog hold short");
    wait_rst(1'b1, 12, "watchdog hold long");
    stay(1'b1, WD - 10, "counter ran during reset");
    wait_rst(1'b0, 30, "counter did not resume");
    wait_rst(1'b1, HOLD + 12, "second release");
    $display("done: expiry");
  endtask : t_expiry
  task automatic t_clear();
    repeat (WD / 2) @(posedge i_ref_clk);
    i_supply_low <= 1'b1;
    repeat (10) @(posedge i_ref_clk);
    i_supply_low <= 1'b0;
    wait_rst(1'b1, HOLD + 20, "supply release");
    stay(1'b1, WD - 10, "counter kept old count");
    wait_rst(1'b0, 30, "watchdog after clear");
    wait_rst(1'b1, HOLD + 12, "release after clear");
    $display("done: clear");
  endtask : t_clear
  task automatic t_float();
    @(posedge i_ref_clk) float_pin <= 1'b1;
    stay(1'b1, 2 * WD, "floating strobe caused reset");
    check({3'h0, o_status.watchdog_armed}, 4'h0, "floating strobe armed");
    @(posedge i_ref_clk) float_pin <= 1'b0;
    wait_rst(1'b0, WD + 20, "reconnected watchdog silent");
    check({3'h0, o_status.cause_watchdog}, 4'h1, "reconnected watchdog cause");
    wait_rst(1'b1, HOLD + 12, "release after float");
    $display("done: float");
  endtask : t_float
  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    service <= 1'b1;
    t_power_up();
    t_supply();
    t_manual();
    t_service();
    t_restart();
    t_expiry();
    t_clear();
    t_float();
    conclude();
  end
endmodule : supply_supervisor_watchdog_reset_test
